// *** include/tgm_pkg.sv ***
package tgm_pkg;
    // Event order: ok pad vlan control pause mcast bcast err
    // frm fcs short check long, bit 0 first
    localparam int N_EV      = 13;
    localparam int EV_CHECK  = 11;
    localparam int CNT_W     = 16;
    localparam int RXD_W     = 8;
    localparam int RXF_DEPTH = 32;
    localparam int RXF_PW    = 5;
    localparam int PRE_W     = 56;
    localparam int IFG_W     = 6;
    localparam int SEL_W     = 5;

    localparam logic [7:0] A_TX_CFG   = 8'h00;
    localparam logic [7:0] A_RX_CFG   = 8'h04;
    localparam logic [7:0] A_PAUSE    = 8'h08;
    localparam logic [7:0] A_IRQ_ST   = 8'h0C;
    localparam logic [7:0] A_IRQ_MASK = 8'h10;
    localparam logic [7:0] A_SEL      = 8'h14;
    localparam logic [7:0] A_CNT      = 8'h18;

    localparam int TXLB_BIT = 8;
    localparam int GFC_BIT  = 0;
    localparam int RXLB_BIT = 1;
    localparam int SEL_DIR  = 4;

    localparam int N_IRQ     = 3;
    localparam int IRQ_TXLEN = 0;
    localparam int IRQ_RXLEN = 1;
    localparam int IRQ_OVF   = 2;

    localparam logic [IFG_W-1:0] IFG_DEFAULT   = 6'h0C;
    localparam logic [15:0]      PAUSE_INT_RST = 16'h0100;
    localparam logic [15:0]      LT_LEN_MAX    = 16'h05DC;
    localparam logic [15:0]      LEN_OVH       = 16'h0012;
    localparam logic [1:0]       HTRANS_NSEQ   = 2'h2;

    typedef enum logic [1:0] {
        P_IDLE = 2'b01,
        P_HOLD = 2'b10
    } tgm_pause_t;

    // Only a field that carries a length can mismatch
    function automatic logic tgm_lt_bad(
        input logic [15:0] lt,
        input logic [15:0] len
    );
        return (lt <= LT_LEN_MAX) && (lt != 16'(len - LEN_OVH));
    endfunction : tgm_lt_bad
endpackage : tgm_pkg

// *** include/tgm_stats_if.sv ***
`timescale 1ns/1ps
interface tgm_stats_if;
    import tgm_pkg::*;
    logic                 pkt_en;
    logic [N_EV-1:0]      ev;
    logic [3:0]           sel;
    logic [CNT_W-1:0]     count;
    modport src  (output pkt_en, output ev, output sel, input count);
    modport bank (input pkt_en, input ev, input sel, output count);
endinterface : tgm_stats_if

// *** logic/tgm_mac_opts.sv ***
// Contract
// - Gap 1..48 fixed per packet, default 12 (the 6-bit parameter takes up to 63)
// - Gap zero: sample register field at end
// - Transmit length check only touches statistics and interrupt
// - Receive length check affects data and statistics
// - Loopback exists only when option set
// - Receive FIFO depth 32 entries
// - Custom preamble signals live only when enabled
// - Flow control from pin or register bit
// - Flow control high stops FIFO reads
// - Enabled counter increments on each event
// - Pause mode: off, port, priority, both
// - Timer option repeats pause at interval
// - Packet qualifier pulses once per packet
// - Length error only for mismatching length field
`timescale 1ns/1ps
module tgm_mac_opts #(
    parameter logic [5:0]  TX_IFG_OPT      = tgm_pkg::IFG_DEFAULT,
    parameter logic        TX_CHECK_OPT    = 1'b0,
    parameter logic        RX_CHECK_OPT    = 1'b0,
    parameter logic        TX_LPBK_OPT     = 1'b0,
    parameter logic        RX_LPBK_OPT     = 1'b0,
    parameter logic        RX_PRE_OPT      = 1'b0,
    parameter logic        GFC_SEL_OPT     = 1'b0,
    parameter logic [12:0] TX_CNT_EN_OPT   = 13'h0000,
    parameter logic [12:0] RX_CNT_EN_OPT   = 13'h0000,
    parameter logic [1:0]  PAUSE_TX_OPT    = 2'h0,
    parameter logic        PAUSE_TIMER_OPT = 1'b0
) (
    input wire logic                      clock,
    input wire logic                      reset_n,
    input wire logic                      tx_reset_n,
    input wire logic                      rx_reset_n,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic [2:0]                hsize,
    input wire logic [31:0]               hwdata,
    input wire logic                      hready,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input wire logic                      tx_end_of_packet_in,
    input wire logic [15:0]               tx_pkt_len,
    input wire logic [15:0]               tx_length_type_field,
    input wire logic [12:0]               tx_events,
    output logic [5:0]                    tx_gap_cnt,
    output logic                          tx_gap_busy,
    output logic                          tx_loopback_en,
    input wire logic                      rx_end_of_packet_in,
    input wire logic [15:0]               rx_pkt_len,
    input wire logic [15:0]               rx_length_type_field,
    input wire logic [12:0]               rx_events,
    input wire logic [tgm_pkg::PRE_W-1:0] rx_preamble_in,
    output logic [tgm_pkg::PRE_W-1:0]     rx_preamble,
    output logic                          rx_preamble_valid,
    output logic                          rx_pkt_discard,
    output logic                          rx_loopback_en,
    input wire logic                      rx_fifo_wr_valid,
    input wire logic [tgm_pkg::RXD_W-1:0] rx_fifo_wr_data,
    output logic                          rx_fifo_wr_ready,
    input wire logic                      rx_gfc_pin,
    output logic                          rx_data_valid,
    output logic [tgm_pkg::RXD_W-1:0]     rx_data,
    input wire logic                      tx_port_pause_req,
    input wire logic                      tx_pfc_req,
    output logic                          tx_port_pause_send,
    output logic                          tx_pfc_send,
    output logic                          irq
);
    import tgm_pkg::*;

    typedef struct packed {
        logic [31:0]       hrdata;
        logic              ph_wr;
        logic [7:0]        ph_addr;
        logic [IFG_W-1:0]  ifg_cfg;
        logic              txlb_req;
        logic              gfc_reg;
        logic              rxlb_req;
        logic [15:0]       pause_int;
        logic [N_IRQ-1:0]  irq_st;
        logic [N_IRQ-1:0]  irq_mask;
        logic [SEL_W-1:0]  sel;
        logic [IFG_W-1:0]  gap_cnt;
        logic [IFG_W-1:0]  gap_left;
        logic              gap_busy;
        logic              tx_pkt_en;
        logic [N_EV-1:0]   tx_ev;
        logic              rx_pkt_en;
        logic [N_EV-1:0]   rx_ev;
        logic [PRE_W-1:0]  pre;
        logic              pre_v;
        logic              discard;
        logic              dv;
        logic [RXD_W-1:0]  d;
        logic [2:0]        gsync;
        logic              gfc_pin_q;
        tgm_pause_t        pst;
        logic [15:0]       ptimer;
        logic              port_send;
        logic              pfc_send;
        logic              irq;
    } tgm_top_t;

    tgm_top_t          s_r;
    tgm_top_t          s_nxt;
    tgm_stats_if       tx_st ();
    tgm_stats_if       rx_st ();
    logic              acc;
    logic              gfc_act;
    logic              tx_bad;
    logic              rx_bad;
    logic              f_valid;
    logic [RXD_W-1:0]  f_data;
    logic [1:0]        preq;
    logic [N_IRQ-1:0]  irq_set;

    tgm_stats_bank #(
        .CNT_EN (TX_CNT_EN_OPT)
    ) u_tx_bank (
        .clock       (clock),
        .reset_n     (reset_n),
        .dir_reset_n (tx_reset_n),
        .st          (tx_st)
    );

    tgm_stats_bank #(
        .CNT_EN (RX_CNT_EN_OPT)
    ) u_rx_bank (
        .clock       (clock),
        .reset_n     (reset_n),
        .dir_reset_n (rx_reset_n),
        .st          (rx_st)
    );

    // reads held off by flow control
    tgm_rx_fifo u_rx_fifo (
        .clock    (clock),
        .reset_n  (reset_n),
        .wr_valid (rx_fifo_wr_valid),
        .wr_data  (rx_fifo_wr_data),
        .wr_ready (rx_fifo_wr_ready),
        .rd_ready (!gfc_act),
        .rd_valid (f_valid),
        .rd_data  (f_data)
    );

    assign tx_st.pkt_en = s_r.tx_pkt_en;
    assign tx_st.ev     = s_r.tx_ev;
    assign tx_st.sel    = s_r.sel[3:0];
    assign rx_st.pkt_en = s_r.rx_pkt_en;
    assign rx_st.ev     = s_r.rx_ev;
    assign rx_st.sel    = s_r.sel[3:0];

    assign gfc_act = GFC_SEL_OPT ? s_r.gfc_pin_q : s_r.gfc_reg;
    assign tx_bad = tgm_lt_bad(tx_length_type_field, tx_pkt_len);
    assign rx_bad = tgm_lt_bad(rx_length_type_field, rx_pkt_len);
    assign preq = {tx_pfc_req && PAUSE_TX_OPT[1],
                   tx_port_pause_req && PAUSE_TX_OPT[0]};
    assign acc  = hsel && hready && (htrans == HTRANS_NSEQ);

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        irq_set = '0;
        s_nxt.port_send = 1'b0;
        s_nxt.pfc_send = 1'b0;
        s_nxt.tx_pkt_en = 1'b0;
        s_nxt.rx_pkt_en = 1'b0;
        s_nxt.dv = 1'b0;
        s_nxt.pre_v = 1'b0;

        // Register bus: read data ready at the data phase
        s_nxt.ph_wr = acc && hwrite;
        s_nxt.ph_addr = haddr[7:0];
        if (acc && !hwrite)
        begin
            case (haddr[7:0])
                A_TX_CFG:
                    s_nxt.hrdata = 32'({s_r.txlb_req, 2'h0, s_r.ifg_cfg});
                A_RX_CFG:
                    s_nxt.hrdata = 32'({s_r.rxlb_req, s_r.gfc_reg});
                A_PAUSE:    s_nxt.hrdata = 32'(s_r.pause_int);
                A_IRQ_ST:   s_nxt.hrdata = 32'(s_r.irq_st);
                A_IRQ_MASK: s_nxt.hrdata = 32'(s_r.irq_mask);
                A_SEL:      s_nxt.hrdata = 32'(s_r.sel);
                A_CNT:
                    s_nxt.hrdata = 32'(s_r.sel[SEL_DIR] ?
                                       rx_st.count : tx_st.count);
                default:    s_nxt.hrdata = 32'h0000_0000;
            endcase
            if (haddr[7:0] == A_IRQ_ST)
                s_nxt.irq_st = '0;
        end
        if (s_r.ph_wr)
        begin
            case (s_r.ph_addr)
                A_TX_CFG:
                begin
                    s_nxt.ifg_cfg = hwdata[IFG_W-1:0];
                    s_nxt.txlb_req = hwdata[TXLB_BIT];
                end
                A_RX_CFG:
                begin
                    s_nxt.gfc_reg = hwdata[GFC_BIT];
                    s_nxt.rxlb_req = hwdata[RXLB_BIT];
                end
                A_PAUSE:    s_nxt.pause_int = hwdata[15:0];
                A_IRQ_MASK: s_nxt.irq_mask = hwdata[N_IRQ-1:0];
                A_SEL:      s_nxt.sel = hwdata[SEL_W-1:0];
                default:    s_nxt.sel = s_r.sel;
            endcase
        end

        //--------------------------------------------------------
        // Transmit gap and statistics
        //--------------------------------------------------------
        if (s_r.gap_left != '0)
            s_nxt.gap_left = s_r.gap_left - 6'h01;
        if (tx_end_of_packet_in)
        begin
            s_nxt.gap_cnt = (TX_IFG_OPT == '0) ? s_r.ifg_cfg : TX_IFG_OPT;
            s_nxt.gap_left = s_nxt.gap_cnt;
            s_nxt.tx_pkt_en = 1'b1;
            s_nxt.tx_ev = tx_events;
            s_nxt.tx_ev[EV_CHECK] = TX_CHECK_OPT && tx_bad;
            irq_set[IRQ_TXLEN] = TX_CHECK_OPT && tx_bad;
        end
        s_nxt.gap_busy = s_nxt.gap_left != '0;

        //--------------------------------------------------------
        // Receive statistics, discard and preamble
        //--------------------------------------------------------
        if (rx_end_of_packet_in)
        begin
            s_nxt.rx_pkt_en = 1'b1;
            s_nxt.rx_ev = rx_events;
            s_nxt.rx_ev[EV_CHECK] = RX_CHECK_OPT && rx_bad;
            s_nxt.discard = RX_CHECK_OPT && rx_bad;
            irq_set[IRQ_RXLEN] = RX_CHECK_OPT && rx_bad;
            s_nxt.pre = RX_PRE_OPT ? rx_preamble_in : '0;
            s_nxt.pre_v = RX_PRE_OPT;
        end
        if (!gfc_act && f_valid)
        begin
            s_nxt.dv = 1'b1;
            s_nxt.d = f_data;
        end
        irq_set[IRQ_OVF] = rx_fifo_wr_valid && !rx_fifo_wr_ready;

        // Pin glitches shorter than two samples never reach the mux
        s_nxt.gsync = {s_r.gsync[1:0], rx_gfc_pin};
        if (s_r.gsync[1] == s_r.gsync[2])
            s_nxt.gfc_pin_q = s_r.gsync[2];

        //--------------------------------------------------------
        // Pause issue
        //--------------------------------------------------------
        case (s_r.pst)
            P_IDLE:
                if (preq != '0)
                begin
                    s_nxt.port_send = preq[0];
                    s_nxt.pfc_send = preq[1];
                    s_nxt.ptimer = s_r.pause_int;
                    s_nxt.pst = P_HOLD;
                end
            P_HOLD:
                if (preq == '0)
                    s_nxt.pst = P_IDLE;
                else if (PAUSE_TIMER_OPT)
                begin
                    if (s_r.ptimer <= 16'h0001)
                    begin
                        s_nxt.port_send = preq[0];
                        s_nxt.pfc_send = preq[1];
                        s_nxt.ptimer = s_r.pause_int;
                    end
                    else
                        s_nxt.ptimer = s_r.ptimer - 16'h0001;
                end
            default:
                s_nxt.pst = P_IDLE;
        endcase

        // A set in the clearing read cycle survives
        s_nxt.irq_st = s_nxt.irq_st | irq_set;
        s_nxt.irq = (s_nxt.irq_st & s_nxt.irq_mask) != '0;

        if (!reset_n)
        begin
            s_nxt = '0;
            s_nxt.ifg_cfg = IFG_DEFAULT;
            s_nxt.pause_int = PAUSE_INT_RST;
            s_nxt.pst = P_IDLE;
        end
    end

    always_ff @(posedge clock)
        s_r <= s_nxt;

    assign hrdata             = s_r.hrdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign tx_gap_cnt         = s_r.gap_cnt;
    assign tx_gap_busy        = s_r.gap_busy;
    assign tx_loopback_en     = TX_LPBK_OPT && s_r.txlb_req;
    assign rx_loopback_en     = RX_LPBK_OPT && s_r.rxlb_req;
    assign rx_preamble        = s_r.pre;
    assign rx_preamble_valid  = s_r.pre_v;
    assign rx_pkt_discard     = s_r.discard;
    assign rx_data_valid      = s_r.dv;
    assign rx_data            = s_r.d;
    assign tx_port_pause_send = s_r.port_send;
    assign tx_pfc_send        = s_r.pfc_send;
    assign irq                = s_r.irq;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    a_gap_fixed: assert property (@(posedge clock) disable iff (!reset_n)
        tx_end_of_packet_in && TX_IFG_OPT != '0
        |=> tx_gap_cnt == TX_IFG_OPT)
        else $error("fixed gap not applied");
    a_gap_dyn: assert property (@(posedge clock) disable iff (!reset_n)
        tx_end_of_packet_in && TX_IFG_OPT == '0
        |=> tx_gap_cnt == $past(s_r.ifg_cfg))
        else $error("dynamic gap not sampled");
    a_tx_check: assert property (@(posedge clock) disable iff (!reset_n)
        tx_end_of_packet_in |=> s_r.tx_pkt_en &&
        s_r.tx_ev[EV_CHECK] == (TX_CHECK_OPT && $past(tx_bad)))
        else $error("tx length check wrong");
    a_rx_drop: assert property (@(posedge clock) disable iff (!reset_n)
        rx_end_of_packet_in
        |=> rx_pkt_discard == (RX_CHECK_OPT && $past(rx_bad)))
        else $error("rx discard wrong");
    a_lpbk_gate: assert property (@(posedge clock) disable iff (!reset_n)
        (tx_loopback_en |-> TX_LPBK_OPT) and
        (rx_loopback_en |-> RX_LPBK_OPT))
        else $error("loopback without option");
    a_pre_off: assert property (@(posedge clock) disable iff (!reset_n)
        !RX_PRE_OPT |-> !rx_preamble_valid && rx_preamble == '0)
        else $error("preamble active while disabled");
    a_gfc_stall: assert property (@(posedge clock) disable iff (!reset_n)
        gfc_act |=> !rx_data_valid)
        else $error("fifo read during flow control");
    a_pause_mode: assert property (@(posedge clock) disable iff (!reset_n)
        (tx_port_pause_send |-> PAUSE_TX_OPT[0]) and
        (tx_pfc_send |-> PAUSE_TX_OPT[1]))
        else $error("pause outside mode");
    a_pause_once: assert property (@(posedge clock) disable iff (!reset_n)
        (tx_port_pause_send || tx_pfc_send) && !PAUSE_TIMER_OPT
        |-> $past(s_r.pst) == P_IDLE)
        else $error("pause repeated without timer");
    a_pkt_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        !tx_end_of_packet_in |=> !s_r.tx_pkt_en)
        else $error("qualifier without packet");

    c_tx_pkt: cover property (@(posedge clock) s_r.tx_pkt_en);
    c_rx_drop: cover property (@(posedge clock) rx_pkt_discard);
    c_gfc: cover property (@(posedge clock) gfc_act && f_valid);
    c_pause: cover property (@(posedge clock) tx_port_pause_send);
endmodule : tgm_mac_opts

// *** logic/tgm_rx_fifo.sv ***
`timescale 1ns/1ps
module tgm_rx_fifo (
    input wire logic                     clock,
    input wire logic                     reset_n,
    input wire logic                     wr_valid,
    input wire logic [tgm_pkg::RXD_W-1:0] wr_data,
    output logic                         wr_ready,
    input wire logic                     rd_ready,
    output logic                         rd_valid,
    output logic [tgm_pkg::RXD_W-1:0]    rd_data
);
    import tgm_pkg::*;

    typedef struct packed {
        logic [RXF_DEPTH-1:0][RXD_W-1:0] mem;
        logic [RXF_PW-1:0]               wp;
        logic [RXF_PW-1:0]               rp;
        logic [RXF_PW:0]                 cnt;
        logic                            rdy;
    } tgm_fifo_t;

    tgm_fifo_t s_r;
    tgm_fifo_t s_nxt;
    logic      w;
    logic      r;

    always_comb
    begin
        s_nxt = s_r;
        w = wr_valid && s_r.rdy;
        r = rd_ready && (s_r.cnt != '0);
        if (w)
        begin
            s_nxt.mem[s_r.wp] = wr_data;
            s_nxt.wp = s_r.wp + 5'h01;
        end
        if (r)
            s_nxt.rp = s_r.rp + 5'h01;
        s_nxt.cnt = s_r.cnt + {5'h00, w} - {5'h00, r};
        s_nxt.rdy = (s_nxt.cnt != 6'(RXF_DEPTH));
        if (!reset_n)
        begin
            s_nxt = '0;
            s_nxt.rdy = 1'b1;
        end
    end

    always_ff @(posedge clock)
        s_r <= s_nxt;

    assign wr_ready = s_r.rdy;
    assign rd_valid = (s_r.cnt != '0);
    assign rd_data  = s_r.mem[s_r.rp];

    a_fifo_full: assert property (@(posedge clock) disable iff (!reset_n)
        !s_r.rdy |-> s_r.cnt == 6'(RXF_DEPTH))
        else $error("fifo refused while not full");
endmodule : tgm_rx_fifo

// *** logic/tgm_stats_bank.sv ***
`timescale 1ns/1ps
module tgm_stats_bank #(
    parameter logic [tgm_pkg::N_EV-1:0] CNT_EN = 13'h0000
) (
    input wire logic  clock,
    input wire logic  reset_n,
    input wire logic  dir_reset_n,
    tgm_stats_if.bank st
);
    import tgm_pkg::*;

    typedef struct packed {
        logic [N_EV-1:0][CNT_W-1:0] cnt;
    } tgm_bank_t;

    tgm_bank_t s_r;
    tgm_bank_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        for (int i = 0; i < N_EV; i++)
        begin
            if (st.pkt_en && st.ev[i] && CNT_EN[i])
                s_nxt.cnt[i] = s_r.cnt[i] + 16'h0001;
        end
        if (!(reset_n && dir_reset_n))
            s_nxt = '0;
    end

    always_ff @(posedge clock)
        s_r <= s_nxt;

    assign st.count = (st.sel < 4'(N_EV)) ? s_r.cnt[st.sel] : '0;

    a_cnt_clear: assert property (@(posedge clock)
        !dir_reset_n |=> s_r == '0)
        else $error("counter bank not cleared");
    a_cnt_hold: assert property (@(posedge clock) disable iff (!reset_n)
        dir_reset_n && !st.pkt_en |=> $stable(s_r))
        else $error("counter moved without packet");
endmodule : tgm_stats_bank

// *** verification/tb_tgm_mac_opts.sv ***
`timescale 1ns/1ps
module tb_tgm_mac_opts;
    import tgm_pkg::*;
    logic clock = 0, reset_n = 0, tx_reset_n = 1, rx_reset_n = 1;
    logic hsel = 1, hwrite = 0, hready, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic tx_end_of_packet_in = 0, rx_end_of_packet_in = 0;
    logic [15:0] tx_pkt_len = 0, tx_length_type_field = 0;
    logic [15:0] rx_pkt_len = 0, rx_length_type_field = 0;
    logic [12:0] tx_events = 0, rx_events = 0;
    logic [5:0] tx_gap_cnt;
    logic tx_gap_busy, tx_loopback_en, rx_preamble_valid, rx_pkt_discard;
    logic rx_loopback_en, rx_fifo_wr_valid, rx_fifo_wr_ready;
    logic rx_gfc_pin = 0, rx_data_valid, tx_port_pause_req = 0;
    logic tx_pfc_req = 0, tx_port_pause_send, tx_pfc_send;
    logic put = 0, slow = 0, busy, gfc_on = 0;
    logic [PRE_W-1:0] rx_preamble_in = 0, rx_preamble, pre;
    logic [RXD_W-1:0] rx_fifo_wr_data, rx_data, put_data = 0;
    logic [31:0] seed = 32'h00BB;
    int fail_count = 0, n_checks = 0, ok_cnt = 0, n_port = 0, n_pfc = 0;
    logic [RXD_W-1:0] exp_q[$];

    always #25 clock = ~clock;
    assign hready = hreadyout;

    // Loopback, preamble, rx counters and pause timer keep their off
    // defaults, so the absent branch of each of those options is checked
    tgm_mac_opts #(.TX_IFG_OPT(6'h00), .TX_CHECK_OPT(1'b1),
        .RX_CHECK_OPT(1'b1), .TX_CNT_EN_OPT(13'h1FFF),
        .PAUSE_TX_OPT(2'h1)) u_tgm_mac_opts (.*);
    tgm_user_src u_tgm_user_src (.clock(clock), .reset_n(reset_n),
        .slow(slow), .put(put), .put_data(put_data), .busy(busy),
        .wr_valid(rx_fifo_wr_valid), .wr_data(rx_fifo_wr_data),
        .wr_ready(rx_fifo_wr_ready));

    // -----------------------------------------
    // Helpers
    // -----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= HTRANS_NSEQ;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({hreadyout, hresp}, 2'b10);
    endtask : bus

    task automatic pkt(input logic rx, input logic [15:0] len, lt);
        logic [12:0] ev;
        ev = 13'(xs());
        if (!rx) ok_cnt += ev[0];
        tx_end_of_packet_in <= !rx;
        rx_end_of_packet_in <= rx;
        {tx_pkt_len, tx_length_type_field, tx_events} <= {len, lt, ev};
        {rx_pkt_len, rx_length_type_field, rx_events} <= {len, lt, ev};
        @(posedge clock);
        tx_end_of_packet_in <= 1'b0;
        rx_end_of_packet_in <= 1'b0;
        @(posedge clock);
    endtask : pkt

    task automatic push(input logic [RXD_W-1:0] b);
        put      <= 1'b1;
        put_data <= b;
        slow     <= ^xs();
        rx_gfc_pin <= ^xs();
        exp_q.push_back(b);
        @(posedge clock);
        put <= 1'b0;
        do @(posedge clock); while (busy !== 1'b0);
    endtask : push

    // -----------------------------------------
    // Receive data scoreboard and sequence
    // -----------------------------------------
    always @(posedge clock)
        if (rx_data_valid === 1'b1)
        begin
            chk(gfc_on, 1'b0);
            chk(exp_q.size() == 0, 1'b0);
            chk(rx_data, exp_q.pop_front());
        end

    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        bus(0, A_TX_CFG, 0, rd); chk(rd, 32'h0000000C);
        bus(0, A_PAUSE, 0, rd); chk(rd, 32'h00000100);
        bus(0, 8'h40, 0, rd); chk(rd, 32'h00000000);
        $display("test reset done");
        bus(1, A_IRQ_MASK, 32'h1, rd);
        pkt(0, 16'h0040, 16'h002E); chk(tx_gap_cnt, 6'h0C);
        bus(1, A_TX_CFG, 32'h130, rd);
        pkt(0, 16'h0040, 16'h0028); chk(tx_gap_cnt, 6'h30);
        chk(tx_gap_busy, 1'b1);
        chk(tx_loopback_en, 1'b0);
        chk(irq, 1'b1);
        bus(0, A_IRQ_ST, 0, rd); chk(rd, 32'h1);
        @(posedge clock); chk(irq, 1'b0);
        pkt(0, 16'h0040, 16'h0800); chk(irq, 1'b0);
        bus(1, A_SEL, 32'h0B, rd);
        bus(0, A_CNT, 0, rd); chk(rd, 32'h1);
        bus(1, A_SEL, 32'h00, rd);
        bus(0, A_CNT, 0, rd); chk(rd, ok_cnt);
        $display("test tx done");
        gfc_on <= 1'b1;
        bus(1, A_RX_CFG, 32'h3, rd);
        pre = {24'(xs()), xs()};
        rx_preamble_in <= pre;
        pkt(1, 16'h0040, 16'h0028); chk(rx_pkt_discard, 1'b1);
        chk(rx_preamble_valid, 1'b0);
        chk(rx_preamble, 56'h0);
        chk(rx_loopback_en, 1'b0);
        pkt(1, 16'h0040, 16'h002E); chk(rx_pkt_discard, 1'b0);
        tx_reset_n <= 1'b0;
        @(posedge clock);
        tx_reset_n <= 1'b1;
        bus(0, A_CNT, 0, rd); chk(rd, 32'h0);
        bus(1, A_SEL, 32'h1B, rd);
        bus(0, A_CNT, 0, rd); chk(rd, 32'h0);
        repeat (RXF_DEPTH) push(8'(xs()));
        repeat (4) @(posedge clock);
        chk(rx_fifo_wr_ready, 1'b0);
        gfc_on <= 1'b0;
        bus(1, A_RX_CFG, 32'h0, rd);
        while (exp_q.size() != 0) @(posedge clock);
        chk(rx_fifo_wr_ready, 1'b1);
        $display("test fifo done");
        bus(1, A_PAUSE, 32'd20, rd);
        tx_port_pause_req <= 1'b1;
        tx_pfc_req <= 1'b1;
        repeat (45)
        begin
            @(posedge clock);
            n_port += tx_port_pause_send;
            n_pfc += tx_pfc_send;
        end
        chk(n_port, 1);
        chk(n_pfc, 0);
        $display("test pause done");
        results();
    end
endmodule : tb_tgm_mac_opts

// *** verification/tgm_user_src.sv ***
`timescale 1ns/1ps
module tgm_user_src
    import tgm_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      reset_n,
    input wire logic                      slow,
    input wire logic                      put,
    input wire logic [tgm_pkg::RXD_W-1:0] put_data,
    output logic                          busy,
    output logic                          wr_valid,
    output logic [tgm_pkg::RXD_W-1:0]     wr_data,
    input wire logic                      wr_ready
);
    logic [3:0] wait_cnt;

    // -----------------------------------------
    // Byte source with optional stall
    // -----------------------------------------
    // Released data is inverted so a stale byte never looks valid
    always @(posedge clock)
    begin
        if (!reset_n)
        begin
            busy     <= 1'b0;
            wr_valid <= 1'b0;
            wr_data  <= 8'h00;
            wait_cnt <= 4'h0;
        end
        else if (wr_valid && wr_ready)
        begin
            wr_valid <= 1'b0;
            busy     <= 1'b0;
            wr_data  <= ~wr_data;
        end
        else if (busy && !wr_valid)
        begin
            if (wait_cnt == 4'h0) wr_valid <= 1'b1;
            wait_cnt <= wait_cnt - 4'h1;
        end
        else if (put && !busy)
        begin
            busy     <= 1'b1;
            wr_data  <= put_data;
            wait_cnt <= slow ? 4'h5 : 4'h0;
        end
    end
endmodule : tgm_user_src
